// file: rtl/mic_top.sv
// mic_top: prioritised vectored interrupt controller with APB registers.
// assumes the core sequencer pushes the program counter on svc.take and
// loads svc.vector; pins are asynchronous, events are on pclk.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// RULE1: enabled pending requests serviced at next tick
// RULE2: fixed priority, vectors 04H to 18H
// RULE3: group sources keep flags, share group flag
// RULE4: group service clears only group flag
// RULE5: control 0 bit 0 is global enable
// RULE6: control 0 layout, bit 7 zero
// RULE7: control 1 layout, bits 7,3 zero
// RULE8: group 0 flags 7..4, enables 3..0
// RULE9: group 1 layout, bits 7,3 zero
// RULE10: pin flag on edge; vector needs enables
// RULE11: two-bit edge select per pin
// RULE12: pin service clears flag and global enable
// RULE13: software enables and sets pin as input
// RULE14: pull-high kept in interrupt use
// RULE15: one filter option for all pins; the peripheral pin always bypasses it
// RULE16: peripheral pin falling edge, assign option
// RULE17: peripheral via group; its flag stays
// RULE18: timer overflow sets flag, vectors 0CH/10H
// RULE19: timer service clears flag and global enable
// RULE20: service pushes counter and loads vector
// RULE21: stack full blocks; disabled requests stay pending
// RULE22: group flag set by enabled source flag
module mic_top #(
    parameter int FILT_LEN = mic_pkg::FILT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_irq_pin_zero,
    input wire logic ext_irq_pin_one,
    input wire logic periph_irq_pin,
    input wire logic [1:0] timer_pin,
    output logic [1:0] timer_pin_filt,
    input wire logic [2:0] pull_high_sel,
    output logic [2:0] pull_high_en,
    input wire mic_pkg::mic_src_t src,
    input wire logic second_phase_tick,
    input wire logic stack_full,
    output mic_pkg::mic_svc_t svc
);
    localparam int NPIN = 5;
    localparam int CW = $clog2(FILT_LEN + 1);

    if (FILT_LEN < 1) begin : g_chk
        $error("FILT_LEN must be at least 1");
    end

    logic [7:0] ctl0_r;
    logic [7:0] ctl1_r;
    logic [7:0] grp0_r;
    logic [7:0] grp1_r;
    logic [7:0] edge_r;
    logic [7:0] cfg_r;
    logic [7:0] last_vec_r;
    logic [31:0] prdata_r;
    logic take_r;
    logic [7:0] vec_r;
    logic [2:0] pull_r;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_clean;
    logic [NPIN-1:0] pin_prev_r;

    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [7:0] wdat;
    logic filt_on;
    logic p0_hit;
    logic p1_hit;
    logic pp_hit;
    logic [7:0] set0;
    logic [7:0] set1;
    logic [7:0] setg0;
    logic [7:0] setg1;
    logic [7:0] clr0;
    logic [7:0] clr1;
    logic grp_set;
    logic take;
    logic [7:0] vec_nxt;
    logic [7:0] svc_clr0;
    logic [7:0] svc_clr1;
    logic rq_p0;
    logic rq_p1;
    logic rq_t0;
    logic rq_t1;
    logic rq_ser;
    logic rq_grp;

    assign pin_raw = {timer_pin, periph_irq_pin,
                      ext_irq_pin_one, ext_irq_pin_zero};
    assign filt_on = cfg_r[mic_pkg::B_FILT_ON];

    // synchroniser per pin and optional noise filter on all but the peripheral pin
    for (genvar i = 0; i < NPIN; i++) begin : g_pin
        logic s1_r;
        logic s2_r;
        logic stab_r;
        logic [CW-1:0] cnt_r;
        // two-stage synchroniser
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                s1_r <= 1'b0;
                s2_r <= 1'b0;
            end else begin
                s1_r <= pin_raw[i];
                s2_r <= s1_r;
            end
        end
        // filter: accept a level after it holds FILT_LEN cycles
        // one option serves all filtered pins [RULE15]
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                stab_r <= 1'b0;
                cnt_r <= '0;
            end else if (!filt_on || i == 2) begin
                stab_r <= s2_r; // peripheral pin bypasses filter
                cnt_r <= '0;
            end else if (s2_r == stab_r) begin
                cnt_r <= '0;
            end else if (cnt_r == CW'(FILT_LEN - 1)) begin
                stab_r <= s2_r;
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + CW'(1);
            end
        end
        assign pin_clean[i] = stab_r;
    end

    // previous cleaned level for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev_r <= '0;
        end else begin
            pin_prev_r <= pin_clean;
        end
    end

    // filtered timer inputs leave through flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_pin_filt <= 2'h0;
        end else begin
            timer_pin_filt <= pin_clean[4:3]; // [RULE15]
        end
    end

    // edge detection against the selector code
    function automatic logic edge_hit(
        input logic [1:0] sel,
        input logic now,
        input logic prev
    );
        logic r;
        r = 1'b0;
        case (sel)
            mic_pkg::EDGE_RISE: r = now & ~prev;
            mic_pkg::EDGE_FALL: r = ~now & prev;
            mic_pkg::EDGE_BOTH: r = now ^ prev;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // pin zero at 1..0, pin one at 3..2 [RULE11]
    assign p0_hit = edge_hit(edge_r[1:0], pin_clean[0], pin_prev_r[0]);
    assign p1_hit = edge_hit(edge_r[3:2], pin_clean[1], pin_prev_r[1]);
    // falling edge only when the pin is assigned [RULE16]
    assign pp_hit = cfg_r[mic_pkg::B_PERIPH_ASSIGN]
                  & ~pin_clean[2] & pin_prev_r[2];

    // hardware set vectors, per register
    always_comb begin
        set0 = 8'h00;
        set1 = 8'h00;
        setg0 = 8'h00;
        setg1 = 8'h00;
        set0[mic_pkg::B_P0_F] = p0_hit; // [RULE10]
        set0[mic_pkg::B_P1_F] = p1_hit; // [RULE10]
        set0[mic_pkg::B_T0_F] = src.timer_zero_ovf; // [RULE18]
        set1[mic_pkg::B_T1_F] = src.timer_one_ovf; // [RULE18]
        set1[mic_pkg::B_SER_F] = src.serial_done;
        // own flags of the group sources [RULE3] [RULE8] [RULE9]
        setg0[7] = pp_hit;
        setg0[6] = src.timebase_one;
        setg0[5] = src.timebase_zero;
        setg0[4] = src.conversion_done;
        setg1[6] = src.low_voltage;
        setg1[5] = src.nvm_done;
        setg1[4] = src.comparator_change;
        // shared flag from any enabled group source [RULE22] [RULE3]
        grp_set = |(setg0[7:4] & grp0_r[3:0])
                | |(setg1[6:4] & grp1_r[2:0]);
        set1[mic_pkg::B_GRP_F] = grp_set;
    end

    // eligible requests: flag and own enable; global enable is applied at arbitration
    assign rq_p0 = ctl0_r[mic_pkg::B_P0_F] & ctl0_r[mic_pkg::B_P0_EN];
    assign rq_p1 = ctl0_r[mic_pkg::B_P1_F] & ctl0_r[mic_pkg::B_P1_EN];
    assign rq_t0 = ctl0_r[mic_pkg::B_T0_F] & ctl0_r[mic_pkg::B_T0_EN];
    assign rq_t1 = ctl1_r[mic_pkg::B_T1_F] & ctl1_r[mic_pkg::B_T1_EN];
    assign rq_ser = ctl1_r[mic_pkg::B_SER_F] & ctl1_r[mic_pkg::B_SER_EN];
    assign rq_grp = ctl1_r[mic_pkg::B_GRP_F] & ctl1_r[mic_pkg::B_GRP_EN];

    // arbitration at the phase tick, fixed priority [RULE1] [RULE2]
    always_comb begin
        take = 1'b0;
        vec_nxt = 8'h00;
        svc_clr0 = 8'h00;
        svc_clr1 = 8'h00;
        // global enable gates all; stack full holds off [RULE5] [RULE21]
        if (second_phase_tick && ctl0_r[mic_pkg::B_GIE] && !stack_full) begin
            take = rq_p0 | rq_p1 | rq_t0 | rq_t1 | rq_ser | rq_grp;
            if (rq_p0) begin
                vec_nxt = mic_pkg::VEC_PIN0;
                svc_clr0[mic_pkg::B_P0_F] = 1'b1; // [RULE12]
            end else if (rq_p1) begin
                vec_nxt = mic_pkg::VEC_PIN1;
                svc_clr0[mic_pkg::B_P1_F] = 1'b1; // [RULE12]
            end else if (rq_t0) begin
                vec_nxt = mic_pkg::VEC_TMR0;
                svc_clr0[mic_pkg::B_T0_F] = 1'b1; // [RULE19]
            end else if (rq_t1) begin
                vec_nxt = mic_pkg::VEC_TMR1;
                svc_clr1[mic_pkg::B_T1_F] = 1'b1; // [RULE19]
            end else if (rq_ser) begin
                vec_nxt = mic_pkg::VEC_SER;
                svc_clr1[mic_pkg::B_SER_F] = 1'b1;
            end else if (rq_grp) begin
                vec_nxt = mic_pkg::VEC_GRP;
                // source flags untouched [RULE4] [RULE17]
                svc_clr1[mic_pkg::B_GRP_F] = 1'b1;
            end
            // any service stops nesting [RULE12] [RULE19]
            svc_clr0[mic_pkg::B_GIE] = take;
        end
    end

    // apb decode
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign wdat = pwdata[7:0];
    always_comb begin
        if (paddr == mic_pkg::OFS_CTL0) begin
            addr_ok = 1'b1;
        end else if (paddr == mic_pkg::OFS_CTL1) begin
            addr_ok = 1'b1;
        end else if (paddr == mic_pkg::OFS_GRP0) begin
            addr_ok = 1'b1;
        end else if (paddr == mic_pkg::OFS_GRP1) begin
            addr_ok = 1'b1;
        end else if (paddr == mic_pkg::OFS_EDGE) begin
            addr_ok = 1'b1;
        end else if (paddr == mic_pkg::OFS_CFG) begin
            addr_ok = 1'b1;
        end else if (paddr == mic_pkg::OFS_STAT) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;

    // combined clear: service clears, hardware set still wins
    assign clr0 = svc_clr0;
    assign clr1 = svc_clr1;

    // control 0: flags and enables [RULE6] [RULE5]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl0_r <= mic_pkg::RST_VAL;
        end else if (wr_en && paddr == mic_pkg::OFS_CTL0) begin
            ctl0_r <= ((wdat & ~clr0) | set0) & mic_pkg::MSK_CTL0;
        end else begin
            ctl0_r <= ((ctl0_r & ~clr0) | set0) & mic_pkg::MSK_CTL0;
        end
    end

    // control 1 [RULE7]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl1_r <= mic_pkg::RST_VAL;
        end else if (wr_en && paddr == mic_pkg::OFS_CTL1) begin
            ctl1_r <= ((wdat & ~clr1) | set1) & mic_pkg::MSK_CTL1;
        end else begin
            ctl1_r <= ((ctl1_r & ~clr1) | set1) & mic_pkg::MSK_CTL1;
        end
    end

    // group 0: source flags cleared by software only [RULE8] [RULE4]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grp0_r <= mic_pkg::RST_VAL;
        end else if (wr_en && paddr == mic_pkg::OFS_GRP0) begin
            grp0_r <= (wdat | setg0) & mic_pkg::MSK_GRP0;
        end else begin
            grp0_r <= grp0_r | setg0;
        end
    end

    // group 1 [RULE9] [RULE4]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grp1_r <= mic_pkg::RST_VAL;
        end else if (wr_en && paddr == mic_pkg::OFS_GRP1) begin
            grp1_r <= (wdat | setg1) & mic_pkg::MSK_GRP1;
        end else begin
            grp1_r <= grp1_r | setg1;
        end
    end

    // edge selectors and configuration options
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_r <= mic_pkg::RST_VAL;
            cfg_r <= mic_pkg::RST_VAL;
        end else if (wr_en && paddr == mic_pkg::OFS_EDGE) begin
            edge_r <= wdat & mic_pkg::MSK_EDGE; // [RULE11]
        end else if (wr_en && paddr == mic_pkg::OFS_CFG) begin
            cfg_r <= wdat & mic_pkg::MSK_CFG; // [RULE15] [RULE16]
        end
    end

    // service pulse and vector to the core sequencer [RULE20]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            take_r <= 1'b0;
            vec_r <= 8'h00;
            last_vec_r <= 8'h00;
        end else begin
            take_r <= take;
            if (take) begin
                vec_r <= vec_nxt;
                last_vec_r <= vec_nxt;
            end
        end
    end
    assign svc.take = take_r;
    assign svc.vector = vec_r;

    // pull-high choice passes unchanged in interrupt use [RULE14]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_r <= 3'h0;
        end else begin
            pull_r <= pull_high_sel;
        end
    end
    assign pull_high_en = pull_r;

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0;
        end else if (rd_en) begin
            if (paddr == mic_pkg::OFS_CTL0) begin
                prdata_r <= {24'h0, ctl0_r};
            end else if (paddr == mic_pkg::OFS_CTL1) begin
                prdata_r <= {24'h0, ctl1_r};
            end else if (paddr == mic_pkg::OFS_GRP0) begin
                prdata_r <= {24'h0, grp0_r};
            end else if (paddr == mic_pkg::OFS_GRP1) begin
                prdata_r <= {24'h0, grp1_r};
            end else if (paddr == mic_pkg::OFS_EDGE) begin
                prdata_r <= {24'h0, edge_r};
            end else if (paddr == mic_pkg::OFS_CFG) begin
                prdata_r <= {24'h0, cfg_r};
            end else if (paddr == mic_pkg::OFS_STAT) begin
                prdata_r <= {16'h0, 3'h0, pin_clean, last_vec_r};
            end else begin
                prdata_r <= 32'h0;
            end
        end
    end
    assign prdata = prdata_r;
endmodule
`default_nettype wire

// file: rtl/mic_pkg.sv
// mic_pkg: constants and carrier types of the interrupt controller.
// assumes APB register access, 32-bit data, one word per register.
`default_nettype none
package mic_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTL0 = 8'h00;
    localparam logic [7:0] OFS_CTL1 = 8'h04;
    localparam logic [7:0] OFS_GRP0 = 8'h08;
    localparam logic [7:0] OFS_GRP1 = 8'h0C;
    localparam logic [7:0] OFS_EDGE = 8'h10;
    localparam logic [7:0] OFS_CFG = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;
    // writable bits per register (others read zero)
    localparam logic [7:0] MSK_CTL0 = 8'h7F;
    localparam logic [7:0] MSK_CTL1 = 8'h77;
    localparam logic [7:0] MSK_GRP0 = 8'hFF;
    localparam logic [7:0] MSK_GRP1 = 8'h77;
    localparam logic [7:0] MSK_EDGE = 8'h0F;
    localparam logic [7:0] MSK_CFG = 8'h03;
    localparam logic [7:0] RST_VAL = 8'h00;
    // control 0 fields
    localparam int B_GIE = 0;
    localparam int B_P0_EN = 1;
    localparam int B_P1_EN = 2;
    localparam int B_T0_EN = 3;
    localparam int B_P0_F = 4;
    localparam int B_P1_F = 5;
    localparam int B_T0_F = 6;
    // control 1 fields
    localparam int B_T1_EN = 0;
    localparam int B_SER_EN = 1;
    localparam int B_GRP_EN = 2;
    localparam int B_T1_F = 4;
    localparam int B_SER_F = 5;
    localparam int B_GRP_F = 6;
    // group register layout: flags sit four above their enables
    localparam int GRP_FLAG_OFS = 4;
    // configuration fields
    localparam int B_FILT_ON = 0;
    localparam int B_PERIPH_ASSIGN = 1;
    // edge selector codes
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // vectors
    localparam logic [7:0] VEC_PIN0 = 8'h04;
    localparam logic [7:0] VEC_PIN1 = 8'h08;
    localparam logic [7:0] VEC_TMR0 = 8'h0C;
    localparam logic [7:0] VEC_TMR1 = 8'h10;
    localparam logic [7:0] VEC_SER = 8'h14;
    localparam logic [7:0] VEC_GRP = 8'h18;
    // default noise filter settle length in cycles
    localparam int FILT_CYC = 4;
    // one-cycle event pulses from internal peripherals
    typedef struct packed {
        logic timer_zero_ovf;
        logic timer_one_ovf;
        logic serial_done;
        logic conversion_done;
        logic timebase_zero;
        logic timebase_one;
        logic comparator_change;
        logic nvm_done;
        logic low_voltage;
    } mic_src_t;
    // service request to the core sequencer
    typedef struct packed {
        logic take;
        logic [7:0] vector;
    } mic_svc_t;
endpackage
`default_nettype wire

// file: sim/mic_checker.sv
// mic_checker: port-level properties of the interrupt controller.
// assumes it is bound into mic_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module mic_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic [2:0] pull_high_sel,
    input wire logic [2:0] pull_high_en,
    input wire logic [1:0] timer_pin,
    input wire logic [1:0] timer_pin_filt,
    input wire logic second_phase_tick,
    input wire logic stack_full,
    input wire mic_pkg::mic_svc_t svc
);
    logic rd_acc;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a read in its access phase
    assign rd_acc = psel && penable && !pwrite;
    // a service request lasts one cycle
    sequence s_one_take;
        svc.take ##1 !svc.take;
    endsequence
    // reserved bits of one register read back as zero
    property p_gap(a, m);
        rd_acc && paddr == a |-> (prdata[7:0] & m) == 8'h00;
    endproperty
    chk_one_take: assert property ($rose(svc.take) |-> s_one_take)
        else $error("service pulse too long");
    chk_take_tick: assert property (svc.take |-> $past(second_phase_tick))
        else $error("service without a tick");
    chk_take_room: assert property (svc.take |-> !$past(stack_full))
        else $error("service while the stack was full");
    chk_vec_legal: assert property (svc.take |-> svc.vector inside {
        8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18})
        else $error("vector outside the table");
    chk_vec_hold: assert property (!svc.take |-> $stable(svc.vector))
        else $error("vector moved without a service");
    chk_pull_keep: assert property (
        presetn |=> pull_high_en == $past(pull_high_sel))
        else $error("pull-high selection lost");
    chk_tmr_filt: assert property (((timer_pin_filt ^
        $past(timer_pin_filt)) & (timer_pin_filt ^
        $past(timer_pin, 4))) == 2'h0) else $error("timer filter skew");
    chk_upper_zero: assert property (rd_acc |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    chk_ctl1_gaps: assert property (p_gap(8'h04, 8'h88))
        else $error("control 1 reserved bit set");
    chk_grp1_gaps: assert property (p_gap(8'h0C, 8'h88))
        else $error("group 1 reserved bit set");
    chk_edge_gaps: assert property (p_gap(8'h10, 8'hF0))
        else $error("edge select reserved bit set");
endmodule
bind mic_top mic_checker u_mic_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pull_high_sel(pull_high_sel), .pull_high_en(pull_high_en),
    .timer_pin(timer_pin), .timer_pin_filt(timer_pin_filt),
    .second_phase_tick(second_phase_tick), .stack_full(stack_full),
    .svc(svc)
);
`default_nettype wire

// file: sim/mic_core_model.sv
// mic_core_model: core sequencer and event sources beside the controller.
// assumes the bench asks for events on fire and a full stack on full_req.
`timescale 1ns/1ns
`default_nettype none
module mic_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire mic_pkg::mic_svc_t svc,
    input wire logic full_req,
    input wire mic_pkg::mic_src_t fire,
    output logic second_phase_tick,
    output logic stack_full,
    output mic_pkg::mic_src_t src
);
    logic [1:0] phase_r;
    logic [7:0] pc_r;
    // four phases a machine cycle; arbitration on the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            phase_r <= 2'h0;
        else
            phase_r <= phase_r + 2'h1;
    end
    assign second_phase_tick = (phase_r == 2'h1);
    // a service loads the counter with the vector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_r <= 8'h00;
        end else if (svc.take) begin
            pc_r <= svc.vector;
        end else begin
            pc_r <= pc_r + 8'h01;
        end
    end
    // stack state and single-cycle event pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_full <= 1'b0;
            src <= 9'h000;
        end else begin
            stack_full <= full_req;
            src <= fire;
        end
    end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// tb_top: self-checking bench for the interrupt controller.
// assumes mic_top, mic_core_model and the bound checker are compiled.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int FL = 1;
    localparam int PW = FL + 6;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] pins = 2'h0;
    logic ppin = 1'b1;
    logic [1:0] tpin = 2'h0;
    logic [1:0] tfilt;
    logic [2:0] pull_sel = 3'h0;
    logic [2:0] pull_en;
    logic tick;
    logic full;
    logic full_req = 1'b0;
    mic_pkg::mic_src_t src;
    mic_pkg::mic_src_t fire = 9'h000;
    mic_pkg::mic_svc_t svc;
    logic [32:0] rd_q[$];
    logic [7:0] vec_q[$];
    logic [7:0] adr [6];
    logic [7:0] msk [6];
    logic [7:0] vecs [6];
    logic [7:0] c0, c1, d, a, f;
    int errors = 0;
    int checked = 0;
    int seed = 12056;
    int i, k;
    always #4 pclk = ~pclk;
    mic_top #(.FILT_LEN(FL)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_irq_pin_zero(pins[0]),
        .ext_irq_pin_one(pins[1]), .periph_irq_pin(ppin),
        .timer_pin(tpin), .timer_pin_filt(tfilt), .pull_high_sel(pull_sel),
        .pull_high_en(pull_en), .src(src), .second_phase_tick(tick),
        .stack_full(full), .svc(svc)
    );
    mic_core_model core (
        .pclk(pclk), .presetn(presetn), .svc(svc), .full_req(full_req),
        .fire(fire), .second_phase_tick(tick), .stack_full(full), .src(src)
    );
    task automatic bad(input string m);
        errors++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic cmp_rd(input logic [32:0] g, input logic [32:0] e);
        checked++;
        if (g !== e)
            bad($sformatf("read %h exp %h", g, e));
    endtask
    task automatic cmp_vec(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e)
            bad($sformatf("vector %h exp %h", g, e));
    endtask
    // take the oldest note whenever a read or a service completes
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            cmp_rd({pslverr, prdata}, rd_q.pop_front());
        if (svc.take === 1'b1) begin
            if (vec_q.size() == 0)
                bad("unexpected service");
            else
                cmp_vec(svc.vector, vec_q.pop_front());
        end
    end
    // one APB transfer, then an idle cycle
    task automatic apb(input logic w, input logic [7:0] ad,
            input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        pull_sel <= 3'($random(seed));
        tpin <= 2'($random(seed));
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] v);
        apb(1'b1, ad, {24'h000000, v});
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        rd_q.push_back({25'h0000000, e});
        apb(1'b0, ad, 32'h00000000);
    endtask
    task automatic wait_take;
        for (int n = 0; n < 40 && vec_q.size() != 0; n++)
            @(posedge pclk);
        if (vec_q.size() != 0) begin
            bad("no service");
            vec_q.delete();
        end
    endtask
    task automatic svc_go(input logic [7:0] c, input logic [7:0] v);
        vec_q.push_back(v);
        wr(adr[0], c);
        wait_take();
    endtask
    task automatic pulse(input logic [8:0] s);
        fire <= s;
        @(posedge pclk);
        fire <= 9'h000;
        repeat (2) @(posedge pclk);
    endtask
    task automatic complete_run;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // adr: control 0, control 1, group 0, group 1, edge, config
    initial begin
        adr = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
        msk = '{8'h7F, 8'h77, 8'hFF, 8'h77, 8'h0F, 8'h03};
        vecs = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 6; i++)
            rd(adr[i], 8'h00);
        rd_q.push_back({1'b1, 32'h00000000});
        apb(1'b0, 8'h1C, 32'h00000000);
        repeat (3) begin
            for (i = 0; i < 6; i++) begin
                d = 8'($random(seed)) & 8'hFE;
                wr(adr[i], d);
                rd(adr[i], d & msk[i]);
                wr(adr[i], 8'h00);
            end
        end
        $display("test registers done");
        c0 = 8'h7E;
        c1 = 8'h77;
        wr(adr[1], c1);
        for (i = 0; i < 6; i++) begin
            svc_go(c0 | 8'h01, vecs[i]);
            if (i < 3)
                c0[4 + i] = 1'b0;
            else
                c1[1 + i] = 1'b0;
            rd(adr[0], c0);
            rd(adr[1], c1);
        end
        $display("test priority done");
        wr(adr[1], 8'h03);
        wr(adr[0], 8'h08);
        pulse(9'h1C0);
        rd(adr[0], 8'h48);
        rd(adr[1], 8'h33);
        svc_go(8'h49, 8'h0C);
        svc_go(8'h09, 8'h10);
        rd(adr[1], 8'h23);
        full_req <= 1'b1;
        wr(adr[0], 8'h09);
        repeat (12) @(posedge pclk);
        vec_q.push_back(8'h14);
        full_req <= 1'b0;
        wait_take();
        rd(adr[1], 8'h03);
        $display("test events done");
        wr(adr[1], 8'h04);
        pulse(9'h020);
        rd(adr[2], 8'h10);
        rd(adr[1], 8'h04);
        wr(adr[2], 8'h07);
        wr(adr[3], 8'h07);
        for (i = 0; i < 6; i++) begin
            a = (i < 3) ? adr[3] : adr[2];
            f = 8'h07 | (8'h01 << ((i < 3) ? 6 - i : 9 - i));
            pulse(9'(1 << i));
            rd(adr[1], 8'h44);
            svc_go(8'h01, 8'h18);
            rd(a, f);
            rd(adr[1], 8'h04);
            wr(a, 8'h07);
        end
        $display("test group done");
        for (k = 0; k < 2; k++) begin
            wr(adr[5], 8'(k));
            f = 8'h06 | (8'h10 << k);
            for (i = 0; i < 4; i++) begin
                wr(adr[0], 8'h06);
                wr(adr[4], 8'(i << (2 * k)));
                pins[k] <= 1'b1;
                repeat (PW) @(posedge pclk);
                rd(adr[0], i[0] ? f : 8'h06);
                wr(adr[0], 8'h06);
                pins[k] <= 1'b0;
                repeat (PW) @(posedge pclk);
                rd(adr[0], i[1] ? f : 8'h06);
            end
        end
        wr(adr[4], 8'h01);
        pins[0] <= 1'b1;
        repeat (PW) @(posedge pclk);
        svc_go(8'h17, 8'h04);
        rd(adr[0], 8'h06);
        $display("test pins done");
        wr(adr[2], 8'h08);
        for (k = 0; k < 2; k++) begin
            wr(adr[5], 8'(2 * k));
            ppin <= 1'b0;
            repeat (PW) @(posedge pclk);
            ppin <= 1'b1;
            repeat (PW) @(posedge pclk);
            rd(adr[2], k ? 8'h88 : 8'h08);
        end
        svc_go(8'h01, 8'h18);
        rd(adr[2], 8'h88);
        $display("test peripheral pin done");
        repeat (4) @(posedge pclk);
        complete_run();
    end
    // cut a hung run short
    initial begin
        #400000;
        bad("timeout");
        complete_run();
    end
endmodule
`default_nettype wire
